// ---- core/rac_pkg.sv ----
// Constants for the region access checker: map, field layout, reset values
package rac_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int REGION_N   = 8;             // Protection structures
	localparam int MASTER_N   = 4;             // Masters, the last one is the DMA
	localparam int CTL_N      = 3;             // Masters with a control register
	localparam int DMA_ID     = 3;             // Master index of the DMA
	localparam int SECURE_CPU = 0;             // Master that keeps a stacked context

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [11:0] SLOT_BYTES    = 12'h020;  // One 32-byte slot per structure
	localparam logic [11:0] OFS_BASE      = 12'h000;  // Base and subregion disables
	localparam logic [11:0] OFS_PERM      = 12'h004;  // Permissions
	localparam logic [11:0] REGION_TOP    = 12'h100;  // End of the structure area
	localparam logic [11:0] CTL_BASE      = 12'h200;  // Master attribute control, one word each
	localparam logic [11:0] FAULT_ADDR_OF = 12'h300;  // Last refused address
	localparam logic [11:0] FAULT_STAT_OF = 12'h304;  // Last refusal status

	////////////////////////////////////////////////////////////////////////////////
	// Base register fields
	localparam int BASE_SUB_LSB = 0;           // Slice-off mask [7:0]
	localparam int BASE_ADR_LSB = 8;           // Base address [31:8]

	////////////////////////////////////////////////////////////////////////////////
	// Permission register fields
	localparam int PERM_UR    = 0;
	localparam int PERM_UW    = 1;
	localparam int PERM_UX    = 2;
	localparam int PERM_PR    = 3;
	localparam int PERM_PW    = 4;
	localparam int PERM_PX    = 5;
	localparam int PERM_OPEN  = 6;             // Open-world flag
	localparam int PERM_SKIP  = 7;             // Context skip on miss
	localparam int PERM_SPAN  = 8;             // Span code [12:8]
	localparam int PERM_EN    = 15;            // Region enable
	localparam int PERM_MASK  = 16;            // Context permit mask [31:16]
	localparam logic [31:0] PERM_RST  = 32'h0001_0000;  // Disabled, mask bit 0 set
	localparam logic [31:0] PERM_KEEP = 32'h0001_0000;  // Hardwired ones
	localparam logic [4:0]  SPAN_MIN  = 5'h07;           // 256 byte region

	////////////////////////////////////////////////////////////////////////////////
	// Master control fields
	localparam int CTL_PRIV  = 0;              // Elevated when set
	localparam int CTL_SEC   = 1;              // Secure when set
	localparam int CTL_CTX   = 4;              // Context id [7:4]
	localparam int CTL_STACK = 8;              // Stacked context [11:8]
	localparam int CTL_PMASK = 16;             // Context permit mask [31:16]
	localparam logic [31:0] CTL_RST = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Which masters bring their own attributes
	localparam logic [MASTER_N-1:0] HAS_PRIV = 4'h3;
	localparam logic [MASTER_N-1:0] HAS_EXEC = 4'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Fault status fields
	localparam int FST_VALID  = 0;
	localparam int FST_MASTER = 1;             // [2:1]
	localparam int FST_WRITE  = 3;
	localparam int FST_EXEC   = 4;

endpackage

// ---- core/rac_region_access_checker.sv ----
// Region access checker: structures, master attributes, APB slave and transfer check
//
// Decided for this implementation: the APB register port and the register addresses.

// Contract
// - Each structure: two registers in 32-byte slot
// - Span code gives power-of-two size, 0x08=512B
// - Eight subregions, set mask bit disables one
// - Only enabled subregions of enabled regions match
// - Six read/write/execute bits, user and elevated
// - Open-world flag clear admits secure transfers only
// - Region context mask, bit 0 always one
// - User fetch needs read and execute bits
// - Grant only if all three checks pass
// - Highest-index matching structure decides
// - No match means transfer allowed
// - Skip flag with context miss continues lower
// - No skip and refused means denied outright
// - Context comes from per-master register field
// - Privilege from control when master lacks it
// - Security from control field per master
// - No execute signal means non-execute access
// - DMA inherits configuring transfer's attributes
// - Stacked context only for secure processor
// - Refused transfer errors, blocked, recorded
// - Context write needs its permit bit set
module rac_region_access_checker
	import rac_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        REQ_VALID,
	input  wire logic [31:0] REQ_ADDR,
	input  wire logic [1:0]  REQ_MASTER,
	input  wire logic        REQ_WRITE,
	input  wire logic        REQ_EXEC,
	input  wire logic        REQ_PRIV,
	input  wire logic        REQ_DMA_CFG,
	output logic             RESP_VALID,
	output logic             RESP_GRANT,
	output logic             RESP_ERROR
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage
	logic [31:0] base_r [REGION_N];         // Base and slice-off mask
	logic [31:0] perm_r [REGION_N];         // Permissions
	logic [31:0] ctl_r  [CTL_N];            // Master attribute control
	logic        dma_priv_r;                // Inherited by the DMA
	logic        dma_sec_r;
	logic [3:0]  dma_ctx_r;
	logic [31:0] fault_addr_r;              // Last refused address
	logic [4:0]  fault_stat_r;              // Last refusal status
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        resp_valid_r;
	logic        resp_grant_r;
	logic        resp_error_r;

	////////////////////////////////////////////////////////////////////////////////
	// Address match of one structure
	function automatic logic region_hit(input logic [31:0] b, input logic [31:0] p, input logic [31:0] a);
		logic [4:0]  span;
		logic [31:0] amask;
		logic [2:0]  sub;
		span  = p[PERM_SPAN +: 5];
		// Codes below the smallest size act as 256 bytes
		if (span < SPAN_MIN) begin
			span = SPAN_MIN;
		end
		// Ones over the offset bits inside the region
		amask = 32'hFFFF_FFFF >> (5'h1F - span);  // Size is 2^(span+1)
		// Subregion index is the top three offset bits
		sub   = 3'((a >> (span - 5'h02)) & 32'h0000_0007);  // Eighth of the region
		// Upper bits must agree with the base; a misaligned base simply drops its low bits
		region_hit = p[PERM_EN] && !b[BASE_SUB_LSB + 32'(sub)]
			&& ((a & ~amask) == ({b[31:BASE_ADR_LSB], 8'h00} & ~amask));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Effective transfer attributes
	logic       eff_priv;
	logic       eff_sec;
	logic       eff_exec;
	logic [3:0] eff_ctx;
	logic       is_dma;

	// Each attribute comes from the master, its control word or the DMA capture
	always_comb begin
		is_dma = (REQ_MASTER == 2'(DMA_ID));
		if (is_dma) begin
			eff_priv = dma_priv_r;
			eff_sec  = dma_sec_r;
			eff_ctx  = dma_ctx_r;
		end else begin
			// Only the two processors bring a privilege signal of their own
			eff_priv = HAS_PRIV[REQ_MASTER] ? REQ_PRIV : ctl_r[REQ_MASTER][CTL_PRIV];
			eff_sec  = ctl_r[REQ_MASTER][CTL_SEC];
			eff_ctx  = ctl_r[REQ_MASTER][CTL_CTX +: 4];
		end
		// Writes never count as fetches, whoever issues them
		eff_exec = HAS_EXEC[REQ_MASTER] & REQ_EXEC & !REQ_WRITE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Search, highest index first
	logic allow;
	logic any_hit;
	logic found;
	logic rwx_ok;
	logic sec_ok;
	logic ctx_ok;

	// The first structure taken decides; the rest are not looked at
	always_comb begin
		allow   = 1'b1;  // Nothing matched: free pass
		any_hit = 1'b0;
		found   = 1'b0;
		rwx_ok  = 1'b0;
		sec_ok  = 1'b0;
		ctx_ok  = 1'b0;
		for (int i = REGION_N - 1; i >= 0; i--) begin
			if (!found && region_hit(base_r[i], perm_r[i], REQ_ADDR)) begin
				any_hit = 1'b1;
				ctx_ok  = perm_r[i][PERM_MASK + 32'(eff_ctx)];
				// Skipping is only for a context miss with the skip flag set
				if (!(perm_r[i][PERM_SKIP] && !ctx_ok)) begin
					found = 1'b1;
					// Access kind picks which permission bits apply
					if (REQ_WRITE) begin
						rwx_ok = eff_priv ? perm_r[i][PERM_PW] : perm_r[i][PERM_UW];
					end else if (eff_exec) begin
						rwx_ok = eff_priv ? (perm_r[i][PERM_PR] & perm_r[i][PERM_PX])
							: (perm_r[i][PERM_UR] & perm_r[i][PERM_UX]);
					end else begin
						rwx_ok = eff_priv ? perm_r[i][PERM_PR] : perm_r[i][PERM_UR];
					end
					// Closed regions admit secure transfers only
					sec_ok = perm_r[i][PERM_OPEN] | eff_sec;
					// A skip region reaching here already hit its context
					allow  = rwx_ok & sec_ok & (perm_r[i][PERM_SKIP] | ctx_ok);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	logic        apb_setup;
	logic        apb_wr;
	logic        in_region;
	logic [2:0]  reg_idx;
	logic        is_perm;
	logic        is_ctl;
	logic [1:0]  ctl_idx;
	logic        mapped;
	logic [31:0] rd_val;

	// Register lookup shared by read and write
	always_comb begin
		apb_setup = PSEL & !PENABLE;
		apb_wr    = PSEL & PENABLE & pready_r & PWRITE;  // Write lands at the access edge
		in_region = (PADDR < REGION_TOP) && (PADDR[4:0] <= OFS_PERM[4:0]) && (PADDR[1:0] == 2'h0);
		reg_idx   = PADDR[7:5];
		is_perm   = (PADDR[4:0] == OFS_PERM[4:0]);
		is_ctl    = (PADDR[11:4] == CTL_BASE[11:4]) && (PADDR[3:2] != 2'(DMA_ID)) && (PADDR[1:0] == 2'h0);
		ctl_idx   = PADDR[3:2];
		// The DMA slot answers without error but holds nothing
		mapped    = in_region || is_ctl || (PADDR == FAULT_ADDR_OF) || (PADDR == FAULT_STAT_OF)
			|| ((PADDR[11:4] == CTL_BASE[11:4]) && (PADDR[1:0] == 2'h0));
		rd_val    = 32'h0000_0000;
		if (in_region) begin
			rd_val = is_perm ? perm_r[reg_idx] : base_r[reg_idx];
		end else if (is_ctl) begin
			rd_val = ctl_r[ctl_idx];
		end else if (PADDR == FAULT_ADDR_OF) begin
			rd_val = fault_addr_r;
		end else if (PADDR == FAULT_STAT_OF) begin
			rd_val = {27'h0000000, fault_stat_r};
		end
		// The DMA slot reads as zero: the DMA owns no control word
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB handshake: one wait-free access phase, data prepared in setup
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			// Every setup is answered in the next cycle; no wait states
			pready_r  <= apb_setup;
			pslverr_r <= apb_setup & !mapped;
			prdata_r  <= (apb_setup & !PWRITE) ? rd_val : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Protection structures
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (int i = 0; i < REGION_N; i++) begin
				base_r[i] <= 32'h0000_0000;
				perm_r[i] <= PERM_RST;  // Enable bit clear
			end
		end else if (apb_wr && in_region) begin
			if (is_perm) begin
				perm_r[reg_idx] <= PWDATA | PERM_KEEP;  // Mask bit 0 stays one
			end else begin
				// Alignment of the base is left to software
				base_r[reg_idx] <= PWDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Master attribute control words
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (int m = 0; m < CTL_N; m++) begin
				ctl_r[m] <= CTL_RST;
			end
		end else if (apb_wr && is_ctl) begin
			// Attribute and mask fields take the write as it comes
			ctl_r[ctl_idx][CTL_PRIV]       <= PWDATA[CTL_PRIV];
			ctl_r[ctl_idx][CTL_SEC]        <= PWDATA[CTL_SEC];
			ctl_r[ctl_idx][CTL_PMASK +: 16] <= PWDATA[CTL_PMASK +: 16];
			// Mask checked as it stood before this write, so one write cannot self-authorise
			if (ctl_r[ctl_idx][CTL_PMASK + 32'(PWDATA[CTL_CTX +: 4])]) begin
				ctl_r[ctl_idx][CTL_CTX +: 4] <= PWDATA[CTL_CTX +: 4];
			end
			if (ctl_idx == 2'(SECURE_CPU)) begin
				ctl_r[ctl_idx][CTL_STACK +: 4] <= PWDATA[CTL_STACK +: 4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DMA attribute capture from the transfer that programs the channel
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			dma_priv_r <= 1'b0;
			dma_sec_r  <= 1'b0;
			dma_ctx_r  <= 4'h0;
		end else if (REQ_VALID && REQ_DMA_CFG && !is_dma && allow) begin
			// A refused programming transfer leaves the old attributes in place
			dma_priv_r <= eff_priv;
			dma_sec_r  <= eff_sec;
			dma_ctx_r  <= eff_ctx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer answer, one cycle after the request
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			resp_valid_r <= 1'b0;
			resp_grant_r <= 1'b0;
			resp_error_r <= 1'b0;
		end else begin
			// Exactly one of grant and error rides with each answer
			resp_valid_r <= REQ_VALID;
			resp_grant_r <= REQ_VALID & allow;   // Only a grant lets it reach the target
			resp_error_r <= REQ_VALID & !allow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault record; a new refusal beats a software clear in the same cycle
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			fault_addr_r <= 32'h0000_0000;
			fault_stat_r <= 5'h00;
		end else if (REQ_VALID && !allow) begin
			fault_addr_r <= REQ_ADDR;
			fault_stat_r <= {eff_exec, REQ_WRITE, REQ_MASTER, 1'b1};
		end else if (apb_wr && PADDR == FAULT_STAT_OF && PWDATA[FST_VALID]) begin
			// Clear only when no refusal lands in the same cycle
			fault_stat_r[FST_VALID] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign PRDATA     = prdata_r;
	assign PREADY     = pready_r;
	assign PSLVERR    = pslverr_r;
	assign RESP_VALID = resp_valid_r;
	assign RESP_GRANT = resp_grant_r;
	assign RESP_ERROR = resp_error_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_free_pass: assert property (@(posedge CLK) disable iff (RESET)
		REQ_VALID && !any_hit |=> RESP_VALID && RESP_GRANT && !RESP_ERROR)
		else $error("unmatched transfer not granted");

	chk_deny_error: assert property (@(posedge CLK) disable iff (RESET)
		RESP_VALID |-> (RESP_GRANT != RESP_ERROR))
		else $error("answer neither granted nor refused exactly once");

	chk_fault_record: assert property (@(posedge CLK) disable iff (RESET)
		REQ_VALID && !allow |=> fault_stat_r[FST_VALID] && fault_addr_r == $past(REQ_ADDR) && RESP_ERROR)
		else $error("refusal not recorded");

	chk_ctx_guard: assert property (@(posedge CLK) disable iff (RESET)
		apb_wr && is_ctl && !ctl_r[ctl_idx][CTL_PMASK + 32'(PWDATA[CTL_CTX +: 4])]
		|=> ctl_r[$past(ctl_idx)][CTL_CTX +: 4] == $past(ctl_r[ctl_idx][CTL_CTX +: 4]))
		else $error("context changed without permit bit");

	chk_mask_bit0: assert property (@(posedge CLK) disable iff (RESET)
		perm_r[0][PERM_MASK] && perm_r[REGION_N-1][PERM_MASK])
		else $error("context mask bit 0 cleared");

	chk_stack_only: assert property (@(posedge CLK) disable iff (RESET)
		ctl_r[1][CTL_STACK +: 4] == 4'h0 && ctl_r[2][CTL_STACK +: 4] == 4'h0)
		else $error("stacked context on a non-secure master");

	chk_exec_forced: assert property (@(posedge CLK) disable iff (RESET)
		REQ_VALID && !HAS_EXEC[REQ_MASTER] |-> !eff_exec)
		else $error("execute taken from a master without one");

	chk_reset_off: assert property (@(posedge CLK)
		$past(RESET) |-> !perm_r[0][PERM_EN] && !perm_r[REGION_N-1][PERM_EN])
		else $error("region enabled straight after reset");

	chk_dma_inherit: assert property (@(posedge CLK) disable iff (RESET)
		REQ_VALID && REQ_DMA_CFG && !is_dma && allow |=> dma_ctx_r == $past(eff_ctx) && dma_sec_r == $past(eff_sec))
		else $error("DMA did not inherit attributes");

	chk_open_secure: assert property (@(posedge CLK) disable iff (RESET)
		REQ_VALID && found && !sec_ok |=> RESP_ERROR && !RESP_GRANT)
		else $error("non-secure transfer passed a closed region");

	chk_answer_once: assert property (@(posedge CLK) disable iff (RESET)
		RESP_VALID == $past(REQ_VALID))
		else $error("answer not paired with a request");

endmodule

// ---- sim/rac_master_model.sv ----
// Bus master model: issues checked transfers and collects the answer
module rac_master_model (
	input  wire logic        clk,
	input  wire logic        resp_valid,
	input  wire logic        resp_grant,
	input  wire logic        resp_error,
	output logic             req_valid,
	output logic [31:0]      req_addr,
	output logic [1:0]       req_master,
	output logic             req_write,
	output logic             req_exec,
	output logic             req_priv,
	output logic             req_dma_cfg
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////////////
	// Idle request lines at time zero
	initial begin
		req_valid = 1'b0;
		req_addr = 32'h0;
		{req_master, req_write, req_exec, req_priv, req_dma_cfg} = 6'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One transfer, held for its taking edge; answer sampled one cycle later
	task automatic send(input logic [1:0] m, input logic [31:0] a, input logic w, x, p, c,
		output logic [2:0] r);
		@(posedge clk);
		req_valid <= 1'b1;
		req_addr <= a;
		{req_master, req_write, req_exec, req_priv, req_dma_cfg} <= {m, w, x, p, c};
		@(posedge clk);
		req_valid <= 1'b0;
		req_addr <= ~a; // Released lines must not mimic the held address
		@(posedge clk);
		r = {resp_valid, resp_error, resp_grant};
	endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench for the region access checker
module tb
	import rac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, resp_valid, resp_grant, resp_error;
	logic        req_valid, req_write, req_exec, req_priv, req_dma_cfg;
	logic [31:0] req_addr;
	logic [1:0]  req_master;
	int          errors = 0;
	int          checks = 0;
	int          cycles = 0;
	// Enabled, open world, span code 8 (512 bytes), no permissions
	localparam logic [31:0] ON = (32'h1 << PERM_EN) | (32'h1 << PERM_OPEN) | (32'h8 << PERM_SPAN);
	localparam logic [31:0] B1 = 32'h1000_5400; // 512-byte aligned base

	rac_region_access_checker dut_u (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_MASTER(req_master),
		.REQ_WRITE(req_write), .REQ_EXEC(req_exec), .REQ_PRIV(req_priv), .REQ_DMA_CFG(req_dma_cfg),
		.RESP_VALID(resp_valid), .RESP_GRANT(resp_grant), .RESP_ERROR(resp_error));
	rac_master_model mdl_u (.clk(clk), .resp_valid(resp_valid), .resp_grant(resp_grant),
		.resp_error(resp_error), .req_valid(req_valid), .req_addr(req_addr), .req_master(req_master),
		.req_write(req_write), .req_exec(req_exec), .req_priv(req_priv), .req_dma_cfg(req_dma_cfg));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the ceiling is far above the planned run
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// APB cycle: wait states allowed, pready is waited for
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic        e;
		apb(1'b1, a, d, v, e);
	endtask
	task automatic region(input int i, input logic [31:0] base, perm);
		wr(SLOT_BYTES * 12'(i) + OFS_BASE, base);
		wr(SLOT_BYTES * 12'(i) + OFS_PERM, perm);
	endtask
	task automatic xfer(input logic [1:0] m, input logic [31:0] a, input logic w, x, p, c, g);
		logic [2:0] r;
		mdl_u.send(m, a, w, x, p, c, r);
		chk("answer", 32'(r), g ? 32'h5 : 32'h6);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		logic [31:0] v;
		logic        e;
		apb(1'b0, SLOT_BYTES * 12'h3 + OFS_PERM, 32'h0, v, e);
		chk("perm reset", v, PERM_RST);
		wr(SLOT_BYTES * 12'h3 + OFS_PERM, 32'h0);
		apb(1'b0, SLOT_BYTES * 12'h3 + OFS_PERM, 32'h0, v, e);
		chk("mask bit0", v, PERM_KEEP);
		xfer(2'd1, B1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		apb(1'b0, 12'h400, 32'h0, v, e);
		chk("unmapped", 32'(e), 32'h1);
		apb(1'b0, CTL_BASE + 12'h00C, 32'h0, v, e);
		chk("dma control", v, 32'h0);
		wr(CTL_BASE, 32'h0000_0F00);
		wr(CTL_BASE + 12'h004, 32'h0000_0F00);
		apb(1'b0, CTL_BASE, 32'h0, v, e);
		chk("stacked m0", 32'(v[11:8]), 32'hF);
		apb(1'b0, CTL_BASE + 12'h004, 32'h0, v, e);
		chk("stacked m1", 32'(v[11:8]), 32'h0);
		wr(CTL_BASE, 32'h0);
		$display("test reset done");
	endtask
	// Subregions 1 and 7 sliced off; edges of the 512-byte span probed
	task automatic t_sub();
		logic [31:0] ofs [7] = '{32'h000, 32'h040, 32'h080, 32'h1BF, 32'h1C0, 32'h200, 32'hFFFF_FFFF};
		logic        gr [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		region(1, B1 | 32'h82, ON);
		for (int k = 0; k < 7; k++) begin
			xfer(2'd1, B1 + ofs[k], 1'b0, 1'b0, 1'b1, 1'b0, gr[k]);
		end
		region(1, B1, ON & ~(32'h1 << PERM_EN));
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		$display("test subregion done");
	endtask
	// Each access kind: exactly its bits grant, one needed bit missing refuses
	task automatic t_perm();
		logic [31:0] nd [6] = '{32'h01, 32'h02, 32'h05, 32'h08, 32'h10, 32'h28};
		logic [31:0] v;
		logic        e;
		for (int k = 0; k < 6; k++) begin
			region(1, B1, ON | nd[k]);
			xfer(2'd1, B1 + 32'h4, k % 3 == 1, k % 3 == 2, k >= 3, 1'b0, 1'b1);
			region(1, B1, ON | (32'h3F & ~(32'h1 << k)));
			xfer(2'd1, B1 + 32'h4, k % 3 == 1, k % 3 == 2, k >= 3, 1'b0, 1'b0);
		end
		apb(1'b0, FAULT_ADDR_OF, 32'h0, v, e);
		chk("fault addr", v, B1 + 32'h4);
		apb(1'b0, FAULT_STAT_OF, 32'h0, v, e);
		chk("fault stat", v & 32'h1F, 32'h13);
		wr(FAULT_STAT_OF, 32'h1);
		apb(1'b0, FAULT_STAT_OF, 32'h0, v, e);
		chk("fault clear", v & 32'h1F, 32'h12);
		region(1, B1, ON | 32'h01);
		xfer(2'd2, B1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		region(1, B1, ON | 32'h08);
		xfer(2'd2, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(CTL_BASE + 12'h008, 32'h1);
		xfer(2'd2, B1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		$display("test permissions done");
	endtask
	task automatic t_sec();
		region(1, B1, (ON & ~(32'h1 << PERM_OPEN)) | 32'h3F);
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(CTL_BASE + 12'h004, 32'h2);
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		$display("test security done");
	endtask
	// Channel programmed elevated, then user, by master 1
	task automatic t_dma();
		region(1, B1, ON | 32'h08);
		xfer(2'd1, 32'h0000_1000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		xfer(2'd3, B1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		xfer(2'd1, 32'h0000_1000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		xfer(2'd3, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		$display("test dma done");
	endtask
	// Master 1 moves to context 2; overlapping structures 1 and 2
	task automatic t_ctx();
		logic [31:0] v;
		logic        e;
		wr(CTL_BASE + 12'h004, 32'h0004_0002);
		wr(CTL_BASE + 12'h004, 32'h0004_0022);
		apb(1'b0, CTL_BASE + 12'h004, 32'h0, v, e);
		chk("ctx allowed", 32'(v[7:4]), 32'h2);
		wr(CTL_BASE + 12'h004, 32'h0004_0032);
		apb(1'b0, CTL_BASE + 12'h004, 32'h0, v, e);
		chk("ctx kept", 32'(v[7:4]), 32'h2);
		region(1, B1, ON | 32'h0004_003F);
		region(2, B1, ON | 32'h0008_003F);
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		region(2, B1, ON | 32'h0008_003F | (32'h1 << PERM_SKIP));
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		region(2, B1, ON | 32'h0004_0000);
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		$display("test context done");
	endtask
	// Reset in mid-run: structures and control words return to rest
	task automatic t_rst_mid();
		logic [31:0] v;
		logic        e;
		region(4, B1, ON);
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, SLOT_BYTES * 12'h4 + OFS_PERM, 32'h0, v, e);
		chk("perm after reset", v, PERM_RST);
		apb(1'b0, CTL_BASE + 12'h004, 32'h0, v, e);
		chk("control after reset", v, CTL_RST);
		xfer(2'd1, B1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		$display("test mid-run reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and run end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_sub();
		t_perm();
		t_sec();
		t_dma();
		t_ctx();
		t_rst_mid();
		tally_and_finish();
	end
endmodule
